// File: design/envelope_decoder.sv
// Envelope decoder: raw pass-through, Biphase and Manchester decoding
// Notes on behaviour
// R1: Timing clock is the carrier oscillator clock
// R2: Speed strap high 2 kbaud, low 4
// R3: Mode floating: raw envelope on data
// R4: Mode low Biphase, high Manchester
// R5: Data valid at decoder clock rising edge
// R6: Open-drain outputs, pull low only
// R7: Straps are three-level, float means mid; the speed strap reads float as high (2 kbaud)
// R8: Amplitude control high enters power down
// R9: Amplitude control low wakes carrier
// R10: Host keys carrier on and off
// R11: Host swings control between supply and 0.8V
// R12: Carrier settles three periods after wake
// R13: Host samples data while clock high
// R14: Valid data gives symmetric decoder clock
// R15: Biphase on Manchester input gives asymmetry
// R16: Bit cells measured in carrier cycles
// R17: Power down releases outputs, resets sync
`timescale 1ns/10ps
module envelope_decoder
	import envelope_decoder_pkg::*;
(
	// System clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// Carrier-derived clock from the oscillator
	input  wire logic carrier_clk_i,
	// Filtered envelope comparator output
	input  wire logic envelope_i,
	// Three-level straps, from window comparators
	input  wire logic baud_lo_i,
	input  wire logic baud_hi_i,
	input  wire logic mode_lo_i,
	input  wire logic mode_hi_i,
	// Amplitude control comparators
	input  wire logic above_shutdown_threshold_i,
	input  wire logic below_wake_threshold_i,
	// Open-drain clock and data
	input  wire logic dec_clk_i,
	output logic      dec_clk_o,
	output logic      dec_clk_oe_o,
	input  wire logic dec_data_i,
	output logic      dec_data_o,
	output logic      dec_data_oe_o,
	// Carrier driver enable
	output logic      carrier_en_o
);
	// ==========================================================
	// Power control in the system domain
	logic ab1_reg, ab2_reg, bw1_reg, bw2_reg;
	logic pd_reg, pd_next;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ab1_reg <= 1'b0;
			ab2_reg <= 1'b0;
			bw1_reg <= 1'b0;
			bw2_reg <= 1'b0;
			pd_reg  <= 1'b1;
		end else begin
			ab1_reg <= above_shutdown_threshold_i;
			ab2_reg <= ab1_reg;
			bw1_reg <= below_wake_threshold_i;
			bw2_reg <= bw1_reg;
			pd_reg  <= pd_next;
		end
	end

	// Hysteresis: between thresholds the state holds
	always_comb begin
		pd_next = pd_reg;
		if (ab2_reg)
			pd_next = 1'b1; // R8
		else if (bw2_reg)
			pd_next = 1'b0; // R9
	end

	// Carrier enable is registered from pd_next, so it drops in the same cycle as pd_reg sets
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			carrier_en_o <= 1'b0;
		else
			carrier_en_o <= !pd_next; // R8 R9
	end

	// ==========================================================
	// Carrier domain: straps and power state crossing
	strap_if st ();

	strap_sync u_sync (
		.carrier_clk_i (carrier_clk_i),
		.rst_n_i       (rst_n_i),
		.baud_lo_i     (baud_lo_i),
		.baud_hi_i     (baud_hi_i),
		.mode_lo_i     (mode_lo_i),
		.mode_hi_i     (mode_hi_i),
		.pd_i          (pd_reg),
		.s             (st.src)
	);

	logic env1_reg, env2_reg, env3_reg;
	dec_state_e state_reg, state_next;
	logic [1:0]       wake_reg, wake_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] hcnt_reg, hcnt_next;
	logic             phase_reg, phase_next;
	logic             bit_reg, bit_next;
	logic             clk_reg, clk_next;
	logic             data_reg, data_next;
	logic [CNT_W-1:0] half;
	logic             edge_seen, short_iv, long_iv;

	always_ff @(posedge carrier_clk_i) begin
		if (!rst_n_i) begin
			env1_reg <= 1'b0;
			env2_reg <= 1'b0;
			env3_reg <= 1'b0;
		end else begin
			env1_reg <= envelope_i;
			env2_reg <= env1_reg;
			env3_reg <= env2_reg;
		end
	end

	// Interval lengths counted in carrier cycles, no crystal needed
	assign half      = half_cell(st.fast); // R2
	assign edge_seen = env2_reg ^ env3_reg;
	assign short_iv  = (cnt_reg >= half - cell_tol(half)) && (cnt_reg <= half + cell_tol(half)); // R1 R16
	assign long_iv   = (cnt_reg > half + cell_tol(half)); // R16

	always_comb begin
		state_next = state_reg;
		wake_next  = wake_reg;
		cnt_next   = (cnt_reg == {CNT_W{1'b1}}) ? cnt_reg : cnt_reg + CNT_W'(1);
		hcnt_next  = hcnt_reg;
		phase_next = phase_reg;
		bit_next   = bit_reg;
		clk_next   = clk_reg;
		data_next  = data_reg;
		case (state_reg)
			DEC_DOWN: begin
				clk_next   = 1'b1; // R17
				data_next  = 1'b1;
				cnt_next   = '0;
				phase_next = 1'b0;
				if (!st.pd) begin
					state_next = DEC_WAKE;
					wake_next  = '0;
				end
			end
			DEC_WAKE: begin
				// Envelope is garbage until the carrier has settled
				wake_next = wake_reg + 2'(1); // R12
				cnt_next  = '0;
				if (wake_reg == WAKE_CNT - 2'(1))
					state_next = DEC_RUN;
			end
			default: begin
				if (st.mode == LVL_FLOAT) begin
					data_next = env2_reg; // R3
					clk_next  = 1'b1;
				end else begin
					// Decoder clock: half cell high, half cell low
					hcnt_next = hcnt_reg + CNT_W'(1); // R14
					if (hcnt_reg >= half - CNT_W'(1)) begin
						hcnt_next = '0;
						clk_next  = !clk_reg;
						if (!clk_reg)
							data_next = bit_reg; // R5
					end
					if (edge_seen) begin
						cnt_next = CNT_W'(1);
						if (st.mode == LVL_LOW) begin
							// Biphase: long gap is one, two short gaps zero
							// Manchester input resyncs off the cell grid: clock loses 50%
							if (long_iv) begin
								bit_next   = 1'b1; // R4
								phase_next = 1'b0;
								hcnt_next  = '0; // R15
							end else if (short_iv) begin
								phase_next = !phase_reg;
								if (phase_reg)
									bit_next = 1'b0;
							end
						end else begin
							// Manchester: mid-cell edge carries the bit
							if (long_iv || phase_reg) begin
								bit_next   = env2_reg; // R4
								phase_next = 1'b0;
								hcnt_next  = '0;
							end else if (short_iv)
								phase_next = 1'b1;
						end
					end
				end
				if (st.pd)
					state_next = DEC_DOWN; // R17
			end
		endcase
	end

	always_ff @(posedge carrier_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= DEC_DOWN;
			wake_reg  <= '0;
			cnt_reg   <= '0;
			hcnt_reg  <= '0;
			phase_reg <= 1'b0;
			bit_reg   <= 1'b0;
			clk_reg   <= 1'b1;
			data_reg  <= 1'b1;
			dec_clk_oe_o  <= 1'b0;
			dec_data_oe_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			wake_reg  <= wake_next;
			cnt_reg   <= cnt_next;
			hcnt_reg  <= hcnt_next;
			phase_reg <= phase_next;
			bit_reg   <= bit_next;
			clk_reg   <= clk_next;
			data_reg  <= data_next;
			// Pin enables kept in flops so the pads see no decode glitches
			dec_clk_oe_o  <= !clk_next; // R6
			dec_data_oe_o <= !data_next; // R6
		end
	end

	// Open drain: drive low only, enable when low
	assign dec_clk_o     = 1'b0; // R6
	assign dec_data_o    = 1'b0;

	// ==========================================================
	// Assertions
	sequence wake_seq;
		(state_reg == DEC_WAKE) [*3];
	endsequence

	pd_release_a: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i) // R17
		state_reg == DEC_DOWN |=> !dec_clk_oe_o && !dec_data_oe_o)
		else $error("outputs driven in power down");
	od_value_a: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i) // R6
		dec_clk_o == 1'b0 && dec_data_o == 1'b0)
		else $error("open drain drives high");
	wake_settle_a: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i) // R12
		state_reg == DEC_DOWN ##1 state_reg == DEC_WAKE |-> wake_seq ##1 state_reg != DEC_WAKE)
		else $error("wake settle not three periods");
	raw_pass_a: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i) // R3
		state_reg == DEC_RUN && st.mode == LVL_FLOAT && !st.pd |=> data_reg == $past(env2_reg))
		else $error("raw envelope not passed");
	data_edge_a: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i) // R5
		state_reg == DEC_RUN && st.mode != LVL_FLOAT && $changed(data_reg) |-> $rose(clk_reg))
		else $error("data changed off clock rise");
	pd_enter_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
		ab2_reg |=> pd_reg && !carrier_en_o)
		else $error("no power down");
	wake_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
		bw2_reg && !ab2_reg |=> !pd_reg && carrier_en_o)
		else $error("no wake");
	clk_sym_a: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i) // R14
		state_reg == DEC_RUN && st.mode != LVL_FLOAT && hcnt_reg >= half - CNT_W'(1) |=> clk_reg != $past(clk_reg))
		else $error("clock half period overrun");
endmodule // envelope_decoder

// File: shared/envelope_decoder_pkg.sv
// Package: constants and types for the RFID envelope decoder
package envelope_decoder_pkg;

	// ==========================================================
	// Carrier and system timing
	localparam int CARRIER_KHZ     = 125;
	localparam int MAX_CARRIER_KHZ = 150;
	localparam int MCLK_MHZ        = 25;

	// ==========================================================
	// Bit cell lengths in carrier cycles
	localparam int BAUD_2K         = 2;
	localparam int BAUD_4K         = 4;
	localparam int CELL_2K         = CARRIER_KHZ / BAUD_2K;
	localparam int CELL_4K         = CARRIER_KHZ / BAUD_4K;
	localparam int CNT_W           = 8;
	localparam logic [CNT_W-1:0] HALF_2K = CNT_W'(CELL_2K / 2);
	localparam logic [CNT_W-1:0] HALF_4K = CNT_W'(CELL_4K / 2);

	// ==========================================================
	// Carrier start-up after wake
	localparam int WAKE_PERIODS    = 3;
	localparam logic [1:0] WAKE_CNT = 2'(WAKE_PERIODS);

	// ==========================================================
	// Three-level strap codes and decoder states
	typedef enum logic [1:0] {
		LVL_LOW   = 2'h0,
		LVL_FLOAT = 2'h1,
		LVL_HIGH  = 2'h2
	} level_e;

	typedef enum logic [2:0] {
		DEC_RUN  = 3'h1,
		DEC_WAKE = 3'h2,
		DEC_DOWN = 3'h4
	} dec_state_e;

	// ==========================================================
	// Shared helpers
	function automatic logic [CNT_W-1:0] half_cell(input logic fast);
		half_cell = fast ? HALF_4K : HALF_2K;
	endfunction

	function automatic logic [CNT_W-1:0] cell_tol(input logic [CNT_W-1:0] half);
		cell_tol = half >> 2;
	endfunction

endpackage

// File: shared/strap_if.sv
// Interface: synchronised strap and power state into the carrier domain
`timescale 1ns/10ps
interface strap_if;
	import envelope_decoder_pkg::*;
	logic   fast;
	level_e mode;
	logic   pd;
	modport src (output fast, output mode, output pd);
	modport dst (input fast, input mode, input pd);
endinterface

// File: design/strap_sync.sv
// Two-flop synchronisers of straps and power-down into the carrier domain
`timescale 1ns/10ps
module strap_sync
	import envelope_decoder_pkg::*;
(
	// Carrier clock
	input  wire logic       carrier_clk_i,
	input  wire logic       rst_n_i,
	// Raw pins
	input  wire logic       baud_lo_i,
	input  wire logic       baud_hi_i,
	input  wire logic       mode_lo_i,
	input  wire logic       mode_hi_i,
	input  wire logic       pd_i,
	strap_if.src            s
);
	logic [4:0] s1_reg, s2_reg;

	always_ff @(posedge carrier_clk_i) begin
		if (!rst_n_i) begin
			s1_reg <= 5'h10;
			s2_reg <= 5'h10;
		end else begin
			s1_reg <= {pd_i, mode_hi_i, mode_lo_i, baud_hi_i, baud_lo_i};
			s2_reg <= s1_reg;
		end
	end

	// Speed is two-level only; floating reads as 2 kbaud (high)
	assign s.fast = s2_reg[0] && !s2_reg[1]; // R2 R7
	assign s.mode = s2_reg[3] ? LVL_HIGH : (s2_reg[2] ? LVL_LOW : LVL_FLOAT); // R7
	assign s.pd   = s2_reg[4];
endmodule // strap_sync

// File: testbench/host_model.sv
// Host model: pull-ups, bit capture and clock duty timing
`timescale 1ns/10ps
module host_model (
	// Carrier clock
	input  wire logic  cclk_i,
	// Pin drivers of the reader
	input  wire logic  clk_oe_i,
	input  wire logic  data_oe_i,
	// Wire levels and captures
	output logic       clk_line_o,
	output logic       data_line_o,
	output logic       bit_o,
	output logic       prev_o,
	output logic [7:0] bit_cnt_o,
	output logic [7:0] hi_len_o,
	output logic [7:0] lo_len_o
);
	// ====================
	// Pull-ups: a released line reads high
	logic [7:0] run_reg;
	logic       last_reg;
	logic       arm_reg;
	assign clk_line_o  = clk_oe_i ? 1'b0 : 1'b1;
	assign data_line_o = data_oe_i ? 1'b0 : 1'b1;
	initial begin
		{bit_o, prev_o, last_reg, arm_reg} = 4'h0;
		{bit_cnt_o, hi_len_o, lo_len_o, run_reg} = 32'h0;
	end
	// ====================
	// Sample two carrier cycles after clock rise, while high
	always @(posedge cclk_i) begin
		arm_reg <= clk_line_o & ~last_reg;
		if (arm_reg && clk_line_o) begin
			prev_o <= bit_o;
			bit_o <= data_line_o;
			bit_cnt_o <= bit_cnt_o + 8'h01;
		end
		if (clk_line_o != last_reg) begin
			if (last_reg) hi_len_o <= run_reg;
			else lo_len_o <= run_reg;
			run_reg <= 8'h01;
		end else run_reg <= run_reg + 8'h01;
		last_reg <= clk_line_o;
	end
endmodule // host_model

// File: testbench/tb_rfid_envelope_decoder.sv
// Testbench of the envelope decoder with a host model
`timescale 1ns/10ps
module tb_rfid_envelope_decoder;
	import envelope_decoder_pkg::*;
	logic       mclk_i  = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       cclk    = 1'b0;
	logic       env     = 1'b0;
	logic       baud_lo = 1'b0;
	logic       baud_hi = 1'b0;
	logic       mode_lo = 1'b0;
	logic       mode_hi = 1'b0;
	logic       above   = 1'b0;
	logic       below   = 1'b1;
	logic       clk_oe, data_oe, carrier_en, clk_line, data_line;
	logic       cap_bit, cap_prev;
	logic [7:0] cap_cnt, hi_len, lo_len;
	int         error_cnt = 0;
	int         tests_run = 0;
	always #20 mclk_i = ~mclk_i;
	always #7.5 cclk = ~cclk;
	envelope_decoder dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .carrier_clk_i(cclk),
		.envelope_i(env), .baud_lo_i(baud_lo), .baud_hi_i(baud_hi), .mode_lo_i(mode_lo),
		.mode_hi_i(mode_hi), .above_shutdown_threshold_i(above), .below_wake_threshold_i(below),
		.dec_clk_i(clk_line), .dec_clk_o(), .dec_clk_oe_o(clk_oe), .dec_data_i(data_line),
		.dec_data_o(), .dec_data_oe_o(data_oe), .carrier_en_o(carrier_en));
	host_model host_u (.cclk_i(cclk), .clk_oe_i(clk_oe), .data_oe_i(data_oe),
		.clk_line_o(clk_line), .data_line_o(data_line), .bit_o(cap_bit), .prev_o(cap_prev),
		.bit_cnt_o(cap_cnt), .hi_len_o(hi_len), .lo_len_o(lo_len));
	// ====================
	// Helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic mcyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// Envelope is sampled by the carrier, so it moves on carrier falls
	task automatic env_step(input int n);
		repeat (n) @(negedge cclk);
		env = ~env;
	endtask
	task automatic wait_en(input logic v);
		for (int i = 0; i < 20 && carrier_en !== v; i++) mcyc(1);
	endtask
	// ====================
	// Scenarios
	task automatic t_raw();
		mode_lo = 1'b0;
		mode_hi = 1'b0;
		for (int k = 0; k < 4; k++) begin
			env = ~env;
			mcyc(4);
			chk(data_line, env);
		end
	endtask
	// Raw mode with low envelope would pull data low if not released
	task automatic t_power();
		for (int k = 0; k < 3; k++) begin
			above = 1'b1;
			below = 1'b0;
			wait_en(1'b0);
			chk(carrier_en, 1'b0);
			mcyc(2);
			chk({clk_oe, data_oe}, 2'h0);
			below = 1'b1;
			mcyc(8);
			chk(carrier_en, 1'b0);
			above = 1'b0;
			wait_en(1'b1);
			chk(carrier_en, 1'b1);
			mcyc(4);
		end
	endtask
	task automatic t_bip();
		mode_lo = 1'b1;
		baud_hi = 1'b1;
		for (int k = 0; k < 16; k++) env_step(2 * HALF_2K);
		mcyc(1);
		chk(cap_bit, 1'b1);
		chk(hi_len, HALF_2K);
		chk(lo_len, HALF_2K);
	endtask
	// Alternating bits give only long intervals, so phase is unique
	task automatic t_man();
		logic [7:0] c0;
		mode_lo = 1'b0;
		mode_hi = 1'b1;
		baud_hi = 1'b0;
		baud_lo = 1'b1;
		for (int k = 0; k < 8; k++) env_step(2 * HALF_4K);
		c0 = cap_cnt;
		for (int k = 0; k < 16; k++) env_step(2 * HALF_4K);
		mcyc(1);
		chk(cap_bit ^ cap_prev, 1'b1);
		chk((cap_cnt - c0) > 8'h0A, 1'b1);
		chk(hi_len, HALF_4K);
		chk(lo_len, HALF_4K);
	endtask
	initial begin
		mcyc(8);
		chk({carrier_en, clk_oe, data_oe}, 3'h0);
		rst_n_i = 1'b1;
		wait_en(1'b1);
		chk(carrier_en, 1'b1);
		mcyc(10);
		t_raw();
		t_power();
		t_bip();
		t_man();
		print_verdict();
	end
	// Scenarios need well under 50 us; this limit is generous
	initial begin
		#1_000_000;
		error_cnt++;
		print_verdict();
	end
endmodule // tb_rfid_envelope_decoder
